// ===== hdl/pwm_regs.sv
// Purpose: Wake, power, reload, misc, timer, gap and serial pin registers
// Assumes: Host strobes and events are one-cycle pulses on core_clk
// Notes: Read data is registered and valid the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: Link change sets bit 6, cleared by host
// R2: Wake frame sets bit 5, cleared by host
// R3: Magic frame sets bit 4, cleared by host
// R4: Three wake enables, zero at reset
// R5: Bit 4 puts regulator into standby
// R6: Mode field 00 normal, cleared on wake
// R7: Light sleep wakes on enabled events
// R8: Deep sleep leaves only on host wake write; a power register write also replaces the mode here
// R9: Host never writes reserved mode 11
// R10: Reload bit starts EEPROM reload, self-clears
// R11: Timer runs only while enable set
// R12: Burst base address bit selectable
// R13: Ring wrap from 40h to start minus one
// R14: Sixteen-bit timer, bytes reset to FFh
// R15: Gap segment one, seven bits, 0Ch
// R16: Gap segment two, seven bits, 12h
// R17: EEPROM clock and select from register
// R18: EEPROM data sampled bit 6, driven bit 5
// R19: PHY data and clock from bits 3, 0
// R20: PHY data output read in bit 2
// R21: Bit 1 sets direction of both lines
// R22: Host bit-bangs serial transactions
module pwm_regs (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] host_page,
  input wire logic [4:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  input wire logic link_change_evt,
  input wire logic wake_frame_evt,
  input wire logic magic_frame_evt,
  input wire logic host_wake_wr,
  output logic wake_event,
  output logic [1:0] power_mode_field,
  output logic light_sleep_state,
  output logic deep_sleep_state,
  output logic regulator_standby,
  output logic nvm_reload_trigger,
  output logic nvm_reload_start,
  input wire logic nvm_reload_done,
  output logic gp_timer_en,
  output logic [15:0] gp_timer_value,
  output logic gp_timer_zero,
  output logic burst_base_select,
  output logic tx_ring_wrap_en,
  input wire logic [7:0] rx_ring_start_page,
  input wire logic [7:0] rdma_page_raw,
  output logic [7:0] rdma_page,
  output logic [15:0] data_window,
  output logic data_window_wr,
  output logic data_window_rd,
  output logic [6:0] gap_segment_one,
  output logic [6:0] gap_segment_two,
  output logic nvm_serial_clock,
  output logic nvm_chip_select,
  output logic nvm_data_pin_o,
  output logic nvm_data_pin_oe,
  input wire logic nvm_data_pin_i,
  output logic phy_mgmt_data_in,
  output logic phy_mgmt_clock,
  output logic phy_mgmt_oe,
  input wire logic phy_mgmt_data_out
);

  logic rst_sync1, rst_n, page3, wr_p3, wake_hit;
  logic [2:0] flags, wake_en, evt_in;
  logic [7:0] gp_timer_low, gp_timer_high, serial_mgmt_pins, next_rdata;
  logic wr_wcs, wr_pm, wr_reload, wr_misc, wr_tlo, wr_thi;
  logic wr_dw, wr_g1, wr_g2, wr_mgmt;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // Address decode, page-3 registers gated by page
  assign page3 = (host_page == pwm_pkg::PAGE_WAKE_REGS);
  assign wr_p3 = host_wr && page3;
  assign wr_wcs = wr_p3 && (host_addr == pwm_pkg::OFS_WAKE_CTRL_STATUS);
  assign wr_pm = wr_p3 && (host_addr == pwm_pkg::OFS_POWER_MGMT);
  assign wr_reload = wr_p3 && (host_addr == pwm_pkg::OFS_NVM_RELOAD);
  assign wr_misc = wr_p3 && (host_addr == pwm_pkg::OFS_MISC_CONTROL);
  assign wr_tlo = wr_p3 && (host_addr == pwm_pkg::OFS_GP_TIMER_LOW);
  assign wr_thi = wr_p3 && (host_addr == pwm_pkg::OFS_GP_TIMER_HIGH);
  assign wr_dw = host_wr && (host_addr == pwm_pkg::OFS_DATA_WINDOW);
  assign wr_g1 = host_wr && (host_addr == pwm_pkg::OFS_FRAME_GAP_SEG1);
  assign wr_g2 = host_wr && (host_addr == pwm_pkg::OFS_FRAME_GAP_SEG2);
  assign wr_mgmt = host_wr && (host_addr == pwm_pkg::OFS_SERIAL_MGMT_PINS);

  // Event order in flags: [2] link, [1] wake frame, [0] magic frame
  assign evt_in = {link_change_evt, wake_frame_evt, magic_frame_evt};
  assign wake_hit = (power_mode_field == pwm_pkg::MODE_LIGHT_SLEEP) &&
    ((evt_in & wake_en) != 3'h0); // [R7] [R4]

  // Sticky event flags, clear by power write or write-one; set wins
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flag
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[gi] <= 1'b0;
        end else if (evt_in[gi]) begin
          flags[gi] <= 1'b1; // [R1] [R2] [R3]
        end else if (wr_pm || (wr_wcs &&
            host_wdata[pwm_pkg::BIT_MAGIC_FRAME_FLAG + gi])) begin
          flags[gi] <= 1'b0; // [R1] [R2] [R3]
        end
      end
    end
  endgenerate

  // Wake enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_en <= 3'h0;
    end else if (wr_wcs) begin
      wake_en <= host_wdata[2:0]; // [R4]
    end
  end

  // Power mode and regulator standby; wake clears mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode_field <= pwm_pkg::MODE_NORMAL;
      regulator_standby <= 1'b0;
    end else begin
      if (wr_pm) begin
        regulator_standby <=
          host_wdata[pwm_pkg::BIT_REGULATOR_STANDBY]; // [R5]
      end
      if (wake_hit || host_wake_wr) begin
        power_mode_field <= pwm_pkg::MODE_NORMAL; // [R6] [R8]
      end else if (wr_pm) begin
        power_mode_field <= host_wdata[1:0]; // Code 11 kept as written [R9]
      end
    end
  end

  // One-cycle pulse when a wake-up ends a sleep mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= wake_hit ||
        (host_wake_wr && (power_mode_field != pwm_pkg::MODE_NORMAL));
    end
  end

  assign light_sleep_state = (power_mode_field == pwm_pkg::MODE_LIGHT_SLEEP);
  assign deep_sleep_state = (power_mode_field == pwm_pkg::MODE_DEEP_SLEEP);

  // Reload trigger held until loader reports done, then self-clears
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_reload_trigger <= 1'b0;
      nvm_reload_start <= 1'b0;
    end else begin
      nvm_reload_start <= wr_reload &&
        host_wdata[pwm_pkg::BIT_NVM_RELOAD_TRIGGER] && !nvm_reload_trigger;
      if (wr_reload && host_wdata[pwm_pkg::BIT_NVM_RELOAD_TRIGGER]) begin
        nvm_reload_trigger <= 1'b1; // [R10]
      end else if (nvm_reload_done) begin
        nvm_reload_trigger <= 1'b0; // [R10]
      end
    end
  end

  // Misc control bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_timer_en <= 1'b0;
      burst_base_select <= 1'b0;
      tx_ring_wrap_en <= 1'b0;
    end else if (wr_misc) begin
      gp_timer_en <= host_wdata[pwm_pkg::BIT_GP_TIMER_EN]; // [R11]
      burst_base_select <= host_wdata[pwm_pkg::BIT_BURST_BASE_SELECT]; // [R12]
      tx_ring_wrap_en <= host_wdata[pwm_pkg::BIT_TX_RING_WRAP_EN]; // [R13]
    end
  end

  // Timer bytes: host write loads, else count down to zero while enabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_timer_low <= pwm_pkg::RST_GP_TIMER_BYTE; // [R14]
      gp_timer_high <= pwm_pkg::RST_GP_TIMER_BYTE; // [R14]
    end else if (wr_tlo || wr_thi) begin
      if (wr_tlo) begin
        gp_timer_low <= host_wdata[7:0];
      end
      if (wr_thi) begin
        gp_timer_high <= host_wdata[7:0];
      end
    end else if (gp_timer_en && (gp_timer_value != 16'h0000)) begin
      {gp_timer_high, gp_timer_low} <= gp_timer_value - 16'h0001; // [R11]
    end
  end

  assign gp_timer_value = {gp_timer_high, gp_timer_low};
  assign gp_timer_zero = (gp_timer_value == 16'h0000);

  // Remote write page, wrapped into the transmit ring when enabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdma_page <= 8'h00;
    end else if (tx_ring_wrap_en &&
        (rdma_page_raw >= rx_ring_start_page)) begin
      rdma_page <= pwm_pkg::TX_RING_BASE_PAGE; // [R13]
    end else begin
      rdma_page <= rdma_page_raw;
    end
  end

  // Data window and frame gap segments
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_window <= 16'h0000;
      gap_segment_one <= pwm_pkg::RST_GAP_SEGMENT_ONE; // [R15]
      gap_segment_two <= pwm_pkg::RST_GAP_SEGMENT_TWO; // [R16]
    end else begin
      if (wr_dw) begin
        data_window <= host_wdata;
      end
      if (wr_g1) begin
        gap_segment_one <= host_wdata[6:0]; // [R15]
      end
      if (wr_g2) begin
        gap_segment_two <= host_wdata[6:0]; // [R16]
      end
    end
  end

  // Strobes to the buffer side for data window traffic
  assign data_window_wr = wr_dw;
  assign data_window_rd = host_rd && (host_addr == pwm_pkg::OFS_DATA_WINDOW);

  // Management pin register; read-only bits never stored
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_mgmt_pins <= 8'h00;
    end else if (wr_mgmt) begin
      serial_mgmt_pins <= host_wdata[7:0] & 8'hbb; // Host bit-bangs [R22]
    end
  end

  // Pin drives straight from register bits; both output enables are the inverted direction bit
  assign nvm_serial_clock =
    serial_mgmt_pins[pwm_pkg::BIT_NVM_SERIAL_CLOCK]; // [R17]
  assign nvm_chip_select =
    serial_mgmt_pins[pwm_pkg::BIT_NVM_CHIP_SELECT]; // [R17]
  assign nvm_data_pin_o =
    serial_mgmt_pins[pwm_pkg::BIT_NVM_DATA_DRIVE]; // [R18]
  assign phy_mgmt_data_in =
    serial_mgmt_pins[pwm_pkg::BIT_PHY_MGMT_DATA_IN]; // [R19]
  assign phy_mgmt_clock =
    serial_mgmt_pins[pwm_pkg::BIT_PHY_MGMT_CLOCK]; // [R19]
  assign nvm_data_pin_oe = !serial_mgmt_pins[pwm_pkg::BIT_MGMT_DIR]; // [R21]
  assign phy_mgmt_oe = !serial_mgmt_pins[pwm_pkg::BIT_MGMT_DIR]; // [R21]

  // Read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    case (host_addr)
      pwm_pkg::OFS_WAKE_CTRL_STATUS: begin
        if (page3) begin
          next_rdata = {1'b0, flags, 1'b0, wake_en};
        end
      end
      pwm_pkg::OFS_POWER_MGMT: begin
        if (page3) begin
          next_rdata = {3'h0, regulator_standby, 2'h0, power_mode_field};
        end
      end
      pwm_pkg::OFS_MISC_CONTROL: begin
        if (page3) begin
          next_rdata = {5'h00, gp_timer_en, burst_base_select,
            tx_ring_wrap_en};
        end
      end
      pwm_pkg::OFS_GP_TIMER_LOW: begin
        if (page3) begin
          next_rdata = gp_timer_low;
        end
      end
      pwm_pkg::OFS_GP_TIMER_HIGH: begin
        if (page3) begin
          next_rdata = gp_timer_high;
        end
      end
      pwm_pkg::OFS_FRAME_GAP_SEG1: begin
        next_rdata = {1'b0, gap_segment_one};
      end
      pwm_pkg::OFS_FRAME_GAP_SEG2: begin
        next_rdata = {1'b0, gap_segment_two};
      end
      pwm_pkg::OFS_SERIAL_MGMT_PINS: begin
        next_rdata = serial_mgmt_pins;
        next_rdata[pwm_pkg::BIT_NVM_DATA_SAMPLE] = nvm_data_pin_i; // [R18]
        next_rdata[pwm_pkg::BIT_PHY_MGMT_DATA_OUT] =
          phy_mgmt_data_out; // [R20]
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Registered read data; data window returns all 16 bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 16'h0000;
    end else if (host_rd) begin
      if (host_addr == pwm_pkg::OFS_DATA_WINDOW) begin
        host_rdata <= data_window;
      end else begin
        host_rdata <= {8'h00, next_rdata};
      end
    end
  end

  // Checks
  sequence link_seen_s;
    link_change_evt;
  endsequence

  sequence pm_write_s;
    wr_pm && !link_change_evt;
  endsequence

  link_flag_set_a: assert property ( // [R1]
    @(posedge core_clk) disable iff (!rst_n)
    link_seen_s |=> flags[2] && (next_rdata[6] || !page3 ||
      host_addr != pwm_pkg::OFS_WAKE_CTRL_STATUS))
    else $error("link change flag not set");
  flag_clear_pm_a: assert property ( // [R2]
    @(posedge core_clk) disable iff (!rst_n)
    pm_write_s and !wake_frame_evt |=> !flags[1])
    else $error("wake frame flag not cleared by power write");
  magic_w1c_a: assert property ( // [R3]
    @(posedge core_clk) disable iff (!rst_n)
    wr_wcs && host_wdata[4] && !magic_frame_evt |=> !flags[0])
    else $error("magic frame flag not cleared by write one");
  regulator_follow_a: assert property ( // [R5]
    @(posedge core_clk) disable iff (!rst_n)
    wr_pm |=> regulator_standby == $past(host_wdata[4]))
    else $error("regulator standby does not follow write");
  light_wake_a: assert property ( // [R7]
    @(posedge core_clk) disable iff (!rst_n)
    light_sleep_state && (evt_in & wake_en) != 3'h0
      |=> power_mode_field == pwm_pkg::MODE_NORMAL && wake_event)
    else $error("light sleep did not wake on enabled event");
  deep_hold_a: assert property ( // [R8]
    @(posedge core_clk) disable iff (!rst_n)
    deep_sleep_state && !host_wake_wr && !wr_pm |=> deep_sleep_state)
    else $error("deep sleep left without host wake write");
  reload_pulse_a: assert property ( // [R10]
    @(posedge core_clk) disable iff (!rst_n)
    wr_reload && host_wdata[0] && !nvm_reload_trigger
      |=> nvm_reload_start ##1 !nvm_reload_start)
    else $error("reload start is not a single pulse");
  timer_hold_a: assert property ( // [R11]
    @(posedge core_clk) disable iff (!rst_n)
    !gp_timer_en && !wr_tlo && !wr_thi |=> $stable(gp_timer_value))
    else $error("timer moved while disabled");
  ring_wrap_a: assert property ( // [R13]
    @(posedge core_clk) disable iff (!rst_n)
    tx_ring_wrap_en && rdma_page_raw >= rx_ring_start_page
      |=> rdma_page == pwm_pkg::TX_RING_BASE_PAGE)
    else $error("ring write page did not wrap to base");
  dir_both_a: assert property ( // [R21]
    @(posedge core_clk) disable iff (!rst_n)
    wr_mgmt |=> nvm_data_pin_oe == !$past(host_wdata[1]) &&
      phy_mgmt_oe == nvm_data_pin_oe)
    else $error("direction bit not applied to both lines");

endmodule

`default_nettype wire

// ===== inc/pwm_pkg.sv
// Purpose: Constants for the power, wake and misc management registers
// Assumes: Byte-wide host registers at 5-bit offsets, data window 16 bits
// Notes: Offsets 0x0a..0x0f answer only while register page 3 is selected
package pwm_pkg;

  // Register offsets
  localparam logic [4:0] OFS_WAKE_CTRL_STATUS = 5'h0a;
  localparam logic [4:0] OFS_POWER_MGMT = 5'h0b;
  localparam logic [4:0] OFS_NVM_RELOAD = 5'h0c;
  localparam logic [4:0] OFS_MISC_CONTROL = 5'h0d;
  localparam logic [4:0] OFS_GP_TIMER_LOW = 5'h0e;
  localparam logic [4:0] OFS_GP_TIMER_HIGH = 5'h0f;
  localparam logic [4:0] OFS_DATA_WINDOW = 5'h10;
  localparam logic [4:0] OFS_FRAME_GAP_SEG1 = 5'h12;
  localparam logic [4:0] OFS_FRAME_GAP_SEG2 = 5'h13;
  localparam logic [4:0] OFS_SERIAL_MGMT_PINS = 5'h14;
  localparam logic [1:0] PAGE_WAKE_REGS = 2'h3;

  // Wake control and status fields
  localparam int BIT_LINK_CHANGE_FLAG = 6;
  localparam int BIT_WAKE_FRAME_FLAG = 5;
  localparam int BIT_MAGIC_FRAME_FLAG = 4;
  localparam int BIT_LINK_CHANGE_WAKE_EN = 2;
  localparam int BIT_WAKE_FRAME_EN = 1;
  localparam int BIT_MAGIC_FRAME_WAKE_EN = 0;

  // Power management fields
  localparam int BIT_REGULATOR_STANDBY = 4;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_LIGHT_SLEEP = 2'h1;
  localparam logic [1:0] MODE_DEEP_SLEEP = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // Reload, misc control and management pin fields
  localparam int BIT_NVM_RELOAD_TRIGGER = 0;
  localparam int BIT_GP_TIMER_EN = 2;
  localparam int BIT_BURST_BASE_SELECT = 1;
  localparam int BIT_TX_RING_WRAP_EN = 0;
  localparam int BIT_NVM_SERIAL_CLOCK = 7;
  localparam int BIT_NVM_DATA_SAMPLE = 6;
  localparam int BIT_NVM_DATA_DRIVE = 5;
  localparam int BIT_NVM_CHIP_SELECT = 4;
  localparam int BIT_PHY_MGMT_DATA_IN = 3;
  localparam int BIT_PHY_MGMT_DATA_OUT = 2;
  localparam int BIT_MGMT_DIR = 1;
  localparam int BIT_PHY_MGMT_CLOCK = 0;

  // Reset values and ring base
  localparam logic [7:0] RST_GP_TIMER_BYTE = 8'hff;
  localparam logic [6:0] RST_GAP_SEGMENT_ONE = 7'h0c;
  localparam logic [6:0] RST_GAP_SEGMENT_TWO = 7'h12;
  localparam logic [7:0] TX_RING_BASE_PAGE = 8'h40;

endpackage

// ===== tb/pwm_pin_model.sv
// Purpose: Serial memory and PHY line partner for the pin register
// Assumes: Clock pins change only on core_clk edges
// Notes: A released, unselected line shows a toggling filler value
`timescale 1ns/10ps
`default_nettype none
module pwm_pin_model #(
  parameter logic [7:0] WORD = 8'hb4 // Arbitrary readout word
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic nvm_serial_clock,
  input wire logic nvm_chip_select,
  input wire logic nvm_data_pin_o,
  input wire logic nvm_data_pin_oe,
  input wire logic phy_mgmt_clock,
  input wire logic phy_mgmt_data_in,
  input wire logic phy_mgmt_oe,
  output logic nvm_data_pin_i,
  output logic phy_mgmt_data_out
);
  logic [7:0] nsr;
  logic [7:0] psr;
  logic nck_q;
  logic pck_q;
  logic tog;
  // Shift one bit per rising serial clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nsr <= WORD;
      psr <= WORD;
      nck_q <= 1'b0;
      pck_q <= 1'b0;
      tog <= 1'b0;
    end else begin
      nck_q <= nvm_serial_clock;
      pck_q <= phy_mgmt_clock;
      tog <= ~tog;
      if (!nvm_chip_select) begin
        nsr <= WORD;
      end else if (nvm_serial_clock && !nck_q) begin
        nsr <= {nsr[6:0], ~nsr[7]};
      end
      if (phy_mgmt_clock && !pck_q) begin
        psr <= {psr[6:0], 1'b0};
      end
    end
  end
  // Line levels: the device drive wins, else partner or filler
  assign nvm_data_pin_i = nvm_data_pin_oe ? nvm_data_pin_o :
    (nvm_chip_select ? nsr[7] : tog);
  assign phy_mgmt_data_out = phy_mgmt_oe ? phy_mgmt_data_in : psr[7];
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the wake, power and misc registers
// Assumes: Strobes and events are single-cycle pulses
// Notes: Serial pin partner lives in its own module
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [4:0] a;
    logic [15:0] rst;
    logic [15:0] w;
    logic [15:0] rb;
  } pwm_row_s;
  localparam logic [7:0] WORD = 8'hb4;
  logic core_clk, nrst, host_wr, host_rd, host_wake_wr, nvm_reload_done;
  logic [1:0] host_page, power_mode_field;
  logic [4:0] host_addr;
  logic [15:0] host_wdata, host_rdata, gp_timer_value, data_window, rv;
  logic [2:0] evt;
  logic [7:0] rx_ring_start_page, rdma_page_raw, rdma_page;
  logic [6:0] gap_segment_one, gap_segment_two;
  logic wake_event, light_sleep_state, deep_sleep_state;
  logic regulator_standby, nvm_reload_trigger, nvm_reload_start;
  logic gp_timer_en, gp_timer_zero, burst_base_select, tx_ring_wrap_en;
  logic data_window_wr, data_window_rd, nvm_serial_clock, nvm_chip_select;
  logic nvm_data_pin_o, nvm_data_pin_oe, nvm_data_pin_i, phy_mgmt_data_in;
  logic phy_mgmt_clock, phy_mgmt_oe, phy_mgmt_data_out;
  int bad_count, n_checks, seen, dw_wr_n, dw_rd_n;
  pwm_row_s rows [10];

  pwm_regs u_dut (
    .core_clk, .nrst, .host_page, .host_addr, .host_wr, .host_rd,
    .host_wdata, .host_rdata, .link_change_evt(evt[2]),
    .wake_frame_evt(evt[1]), .magic_frame_evt(evt[0]), .host_wake_wr,
    .wake_event, .power_mode_field, .light_sleep_state, .deep_sleep_state,
    .regulator_standby, .nvm_reload_trigger, .nvm_reload_start,
    .nvm_reload_done, .gp_timer_en, .gp_timer_value, .gp_timer_zero,
    .burst_base_select, .tx_ring_wrap_en, .rx_ring_start_page,
    .rdma_page_raw, .rdma_page, .data_window, .data_window_wr,
    .data_window_rd, .gap_segment_one, .gap_segment_two, .nvm_serial_clock,
    .nvm_chip_select, .nvm_data_pin_o, .nvm_data_pin_oe, .nvm_data_pin_i,
    .phy_mgmt_data_in, .phy_mgmt_clock, .phy_mgmt_oe, .phy_mgmt_data_out
  );
  pwm_pin_model #(.WORD(WORD)) u_pins (
    .core_clk, .nrst, .nvm_serial_clock, .nvm_chip_select, .nvm_data_pin_o,
    .nvm_data_pin_oe, .phy_mgmt_clock, .phy_mgmt_data_in, .phy_mgmt_oe,
    .nvm_data_pin_i, .phy_mgmt_data_out
  );

  // Count data window strobes as the design samples them
  always @(posedge core_clk) begin
    if (data_window_wr) dw_wr_n <= dw_wr_n + 1;
    if (data_window_rd) dw_rd_n <= dw_rd_n + 1;
  end

  // Compare a multi-bit value
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // Compare a single flag or pin
  task automatic chk_b(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %b got %b", n, e, g);
    end
  endtask
  // Host write: strobe for one cycle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask
  // Host read: data is taken once the strobe edge has landed
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge core_clk);
    host_rd <= 1'b0;
    @(negedge core_clk);
    d = host_rdata;
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    rd(a, rv);
    chk($sformatf("reg %h", a), e, rv);
  endtask
  // Event and host wake pulses
  task automatic pulse(input logic [2:0] e, input logic hw);
    @(posedge core_clk);
    evt <= e;
    host_wake_wr <= hw;
    @(posedge core_clk);
    evt <= 3'h0;
    host_wake_wr <= 1'b0;
  endtask
  // Expect a single-cycle wake pulse, or none
  task automatic wake_chk(input logic e);
    seen = 0;
    repeat (4) begin
      @(negedge core_clk);
      if (wake_event === 1'b1) seen++;
    end
    chk_b("wake_event", e, seen == 1);
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Cut a hung run short
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    host_page = 2'h3;
    host_addr = 5'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 16'h0000;
    host_wake_wr = 1'b0;
    nvm_reload_done = 1'b0;
    evt = 3'h0;
    rx_ring_start_page = 8'h60;
    rdma_page_raw = 8'h00;
    rows = '{'{5'h0a, 16'h0000, 16'h0007, 16'h0007},
             '{5'h0b, 16'h0000, 16'h0010, 16'h0010},
             '{5'h0c, 16'h0000, 16'h0000, 16'h0000},
             '{5'h0d, 16'h0000, 16'h0003, 16'h0003},
             '{5'h0e, 16'h00ff, 16'h005a, 16'h005a},
             '{5'h0f, 16'h00ff, 16'h00c3, 16'h00c3},
             '{5'h10, 16'h0000, 16'ha5c3, 16'ha5c3},
             '{5'h12, 16'h000c, 16'h00ff, 16'h007f},
             '{5'h13, 16'h0012, 16'h0080, 16'h0000},
             '{5'h14, 16'h0000, 16'h00b9, 16'h00fd}};
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].rb);
    end
    chk_b("regulator_standby", 1'b1, regulator_standby);
    chk_b("burst_base_select", 1'b1, burst_base_select);
    chk("gaps", 16'h7f00, {1'b0, gap_segment_one, 1'b0,
        gap_segment_two});
    chk("data_window", 16'ha5c3, data_window);
    chk_b("tx_ring_wrap_en", 1'b1, tx_ring_wrap_en);
    chk("pins", 16'h007f, {9'h0, nvm_serial_clock, nvm_chip_select,
        nvm_data_pin_o, phy_mgmt_data_in, phy_mgmt_clock, nvm_data_pin_oe,
        phy_mgmt_oe});
    $display("test table done");
    // Wrong page and unmapped offset are refused
    @(posedge core_clk);
    host_page <= 2'h0;
    wr(5'h0e, 16'h0011);
    rc(5'h0a, 16'h0000);
    @(posedge core_clk);
    host_page <= 2'h3;
    rc(5'h0e, 16'h005a);
    rc(5'h11, 16'h0000);
    // Ring wrap at the start page, then pass-through
    @(posedge core_clk);
    rdma_page_raw <= 8'h60;
    repeat (2) @(negedge core_clk);
    chk("rdma_page", 16'h0040, {8'h00, rdma_page});
    @(posedge core_clk);
    rdma_page_raw <= 8'h5f;
    repeat (2) @(negedge core_clk);
    chk("rdma_page", 16'h005f, {8'h00, rdma_page});
    $display("test refuse and ring done");
    // Timer holds while disabled, counts down to zero when enabled
    wr(5'h0e, 16'h0005);
    wr(5'h0f, 16'h0000);
    repeat (10) @(negedge core_clk);
    chk("gp_timer_value", 16'h0005, gp_timer_value);
    wr(5'h0d, 16'h0004);
    rdma_page_raw <= 8'h60;
    repeat (10) @(negedge core_clk);
    chk("gp_timer_value", 16'h0000, gp_timer_value);
    chk_b("gp_timer_zero", 1'b1, gp_timer_zero);
    chk_b("gp_timer_en", 1'b1, gp_timer_en);
    chk_b("burst_base_select", 1'b0, burst_base_select);
    chk("rdma_page", 16'h0060, {8'h00, rdma_page});
    $display("test timer done");
    // Flags set by events, cleared by write-one and by power write
    for (int i = 0; i < 3; i++) begin
      pulse(3'h1 << i, 1'b0);
      rc(5'h0a, 16'h0007 | (16'h0010 << i));
      wr(5'h0a, 16'h0007 | (16'h0010 << i));
      rc(5'h0a, 16'h0007);
    end
    pulse(3'h7, 1'b0);
    wr(5'h0b, 16'h0000);
    rc(5'h0a, 16'h0007);
    chk_b("regulator_standby", 1'b0, regulator_standby);
    $display("test flags done");
    // Light sleep wakes on each enabled event
    for (int i = 0; i < 3; i++) begin
      wr(5'h0b, 16'h0001);
      pulse(3'h1 << i, 1'b0);
      wake_chk(1'b1);
      chk("mode", 16'h0000, {14'h0, power_mode_field});
    end
    wr(5'h0a, 16'h0000);
    wr(5'h0b, 16'h0001);
    pulse(3'h7, 1'b0);
    wake_chk(1'b0);
    chk_b("light_sleep_state", 1'b1, light_sleep_state);
    // Deep sleep ignores events, leaves on host wake write
    wr(5'h0a, 16'h0007);
    wr(5'h0b, 16'h0002); // Never the reserved code
    pulse(3'h7, 1'b0);
    wake_chk(1'b0);
    chk_b("deep_sleep_state", 1'b1, deep_sleep_state);
    pulse(3'h0, 1'b1);
    wake_chk(1'b1);
    chk("mode", 16'h0000, {14'h0, power_mode_field});
    $display("test sleep done");
    // Reload trigger starts once and clears itself
    wr(5'h0c, 16'h0001);
    @(negedge core_clk);
    chk("reload", 16'h0003, {14'h0, nvm_reload_trigger,
        nvm_reload_start});
    @(negedge core_clk);
    chk("reload", 16'h0002, {14'h0, nvm_reload_trigger,
        nvm_reload_start});
    @(posedge core_clk);
    nvm_reload_done <= 1'b1;
    @(posedge core_clk);
    nvm_reload_done <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk_b("nvm_reload_trigger", 1'b0, nvm_reload_trigger);
    rc(5'h0c, 16'h0000);
    $display("test reload done");
    // Mid-run reset restores every default
    do_reset();
    foreach (rows[i]) rc(rows[i].a, rows[i].rst);
    chk_b("pin_oe", 1'b1, nvm_data_pin_oe);
    $display("test reset done");
    // Bit-banged read of the serial partners with lines released
    wr(5'h14, 16'h0012);
    @(negedge core_clk);
    chk("dir", 16'h0000, {14'h0, nvm_data_pin_oe, phy_mgmt_oe});
    for (int i = 7; i >= 0; i--) begin
      rd(5'h14, rv);
      chk("bits", {14'h0, WORD[i], WORD[i]},
          {14'h0, rv[6], rv[2]});
      wr(5'h14, 16'h0093);
      wr(5'h14, 16'h0012);
    end
    $display("test serial done");
    chk("dw_strobes", 16'h0102, {dw_wr_n[7:0], dw_rd_n[7:0]});
    end_sim();
  end
endmodule
`default_nettype wire
